// file: design/pst_consts.vh
// Operation
// - Low ops reach lower word directly
// - Upper byte reachable only by high ops
// - Program counter advances two per word
// - Two 16-bit spaces share one range
// - Byte and word mode on every op
// - Word low read returns bits 15..0
// - Byte low read picks byte by select
// - Word high read zero-extends bits 23..16
// - Byte high read phantom byte reads zero
// - Writes use byte and word granularity
// - Page comes from table page register
// - Page msb selects configuration space
`ifndef PST_CONSTS_VH
`define PST_CONSTS_VH
`define PST_OP_RD_LO      2'h0
`define PST_OP_RD_HI      2'h1
`define PST_OP_WR_LO      2'h2
`define PST_OP_WR_HI      2'h3
`define PST_PAGE_CFG_BIT  7
`define PST_PAGE_RST      8'h00
`define PST_PC_STEP       24'h000002
`define PST_PC_RST        24'h000000
`endif

// file: design/pst_table_access.v
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "pst_consts.vh"
module pst_table_access #(
  parameter PAGE_W = 8,
  parameter OFS_W  = 16
) (
  input  wire                    sys_clk,
  input  wire                    rst_n,
  input  wire                    page_wr,
  input  wire [PAGE_W-1:0]       page_wdata,
  input  wire                    op_valid,
  input  wire [1:0]              op_code,
  input  wire                    op_byte,
  input  wire [OFS_W-1:0]        op_offset,
  input  wire [15:0]             op_wdata,
  input  wire                    pc_step,
  input  wire [23:0]             mem_rdata,
  output reg  [PAGE_W-1:0]       table_page_select,
  output reg  [PAGE_W+OFS_W-1:0] mem_addr_q,
  output reg                     mem_cfg_q,
  output reg                     mem_rd_q,
  output reg                     mem_wr_q,
  output reg  [2:0]              mem_lane_q,
  output reg  [23:0]             mem_wdata_q,
  output reg  [15:0]             rd_data_q,
  output reg                     rd_valid_q,
  output reg  [23:0]             pc_q
);
  reg                      rd_pend_q;
  reg                      rd_hi_q;
  reg                      rd_byte_q;
  reg                      rd_bsel_q;
  reg  [2:0]               lane_d;
  reg  [23:0]              wdata_d;
  reg  [15:0]              rdat_d;
  wire                     is_hi = op_code[0];
  wire                     is_wr = op_code[1];
  wire                     bsel  = op_offset[0];

  // Lane encoding: bit0 = P<7:0>, bit1 = P<15:8>, bit2 = P<23:16>
  always @* begin
    lane_d  = 3'h0;
    wdata_d = 24'h000000;
    if (is_hi) begin
      wdata_d = {op_wdata[7:0], 16'h0000};
      // Phantom byte has no storage, so writes to it touch nothing
      if (op_byte)
        lane_d = bsel ? 3'h0 : 3'h4;
      else
        lane_d = 3'h4;
    end else begin
      if (op_byte) begin
        lane_d  = bsel ? 3'h2 : 3'h1;
        wdata_d = {8'h00, op_wdata[7:0], op_wdata[7:0]};
      end else begin
        lane_d  = 3'h3;
        wdata_d = {8'h00, op_wdata};
      end
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n)
      table_page_select <= `PST_PAGE_RST;
    else if (page_wr)
      table_page_select <= page_wdata;
  end

  always @(posedge sys_clk) begin
    if (!rst_n)
      pc_q <= `PST_PC_RST;
    else if (pc_step)
      pc_q <= pc_q + `PST_PC_STEP;
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      mem_addr_q  <= {(PAGE_W+OFS_W){1'b0}};
      mem_cfg_q   <= 1'b0;
      mem_rd_q    <= 1'b0;
      mem_wr_q    <= 1'b0;
      mem_lane_q  <= 3'h0;
      mem_wdata_q <= 24'h000000;
      rd_pend_q   <= 1'b0;
      rd_hi_q     <= 1'b0;
      rd_byte_q   <= 1'b0;
      rd_bsel_q   <= 1'b0;
    end else begin
      mem_rd_q  <= op_valid && !is_wr;
      mem_wr_q  <= op_valid && is_wr;
      rd_pend_q <= op_valid && !is_wr;
      if (op_valid) begin
        // Word mode ignores offset lsb; both spaces share one word address
        mem_addr_q  <= {table_page_select, op_offset[OFS_W-1:1], 1'b0};
        mem_cfg_q   <= table_page_select[`PST_PAGE_CFG_BIT];
        mem_lane_q  <= lane_d;
        mem_wdata_q <= wdata_d;
        rd_hi_q     <= is_hi;
        rd_byte_q   <= op_byte;
        rd_bsel_q   <= bsel;
      end
    end
  end

  // Memory answers combinationally in the cycle after the request
  always @* begin
    rdat_d = 16'h0000;
    if (rd_hi_q) begin
      if (!(rd_byte_q && rd_bsel_q))
        rdat_d = {8'h00, mem_rdata[23:16]};
    end else if (rd_byte_q) begin
      rdat_d = {8'h00, rd_bsel_q ? mem_rdata[15:8] : mem_rdata[7:0]};
    end else begin
      rdat_d = mem_rdata[15:0];
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_data_q  <= 16'h0000;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_pend_q;
      if (rd_pend_q)
        rd_data_q <= rdat_d;
    end
  end
endmodule

// file: verification/pst_mem_model.sv
`timescale 1ns/1ps
module pst_mem_model (
  input  wire        rd,
  input  wire [23:0] addr,
  output wire [23:0] rdata
);
  // Inverted when idle so stale data never passes
  assign rdata = {addr[8:1], addr[15:0] ^ 16'h9a65} ^ {24{!rd}};
endmodule

// file: verification/pst_table_access_asserts.sv
`timescale 1ns/1ps
module pst_table_access_asserts (
  input wire        sys_clk,
  input wire        rst_n,
  input wire        op_valid,
  input wire [1:0]  op_code,
  input wire        pc_step,
  input wire [23:0] mem_rdata,
  input wire        mem_rd_q,
  input wire        mem_wr_q,
  input wire [2:0]  mem_lane_q,
  input wire [15:0] rd_data_q,
  input wire        rd_valid_q,
  input wire [23:0] pc_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_rd_strobe: assert property (op_valid && op_code == 2'h0 |=> mem_rd_q) else $error("rd");
  a_lo_lane: assert property (op_valid && op_code == 2'h2 |=> !mem_lane_q[2]) else $error("lo");
  a_hi_lane: assert property (op_valid && op_code == 2'h3 |=> mem_wr_q && !mem_lane_q[1:0])
    else $error("hi");
  a_wr_no_rd: assert property (op_valid && op_code[1] |=> !mem_rd_q) else $error("wr");
  a_word_low: assert property (mem_rd_q && mem_lane_q == 3'h3 |=>
    rd_data_q == $past(mem_rdata[15:0])) else $error("word");
  a_hi_zero: assert property (op_valid && op_code == 2'h1 |=> ##1 rd_data_q[15:8] == 8'h00)
    else $error("phantom");
  a_pc_step: assert property (pc_step |=> pc_q == $past(pc_q) + 24'h2) else $error("pc");
  a_pc_hold: assert property (!pc_step |=> $stable(pc_q)) else $error("pc hold");
  a_rd_valid: assert property (mem_rd_q |=> rd_valid_q) else $error("valid");
endmodule
bind pst_table_access pst_table_access_asserts i_chk (.*);

// file: verification/pst_table_access_tb.sv
`timescale 1ns/1ps
module pst_table_access_tb;
  reg         sys_clk = 0, rst_n = 0, page_wr = 0, op_valid = 0, op_byte = 0, pc_step = 0;
  reg  [1:0]  op_code = 0;
  reg  [15:0] op_offset = 0;
  wire [23:0] mem_rdata, mem_addr_q, mem_wdata_q, pc_q;
  wire [15:0] rd_data_q;
  wire [7:0]  table_page_select;
  wire [2:0]  mem_lane_q;
  wire        mem_cfg_q, mem_rd_q, mem_wr_q, rd_valid_q;
  integer     errors = 0, n_tests = 0;
  always #10 sys_clk = ~sys_clk;
  pst_table_access i_dut (.*, .page_wdata(op_offset[7:0]), .op_wdata(op_offset));
  pst_mem_model i_mem (.rd(mem_rd_q), .addr(mem_addr_q), .rdata(mem_rdata));
  task chk(input [23:0] s, e);
    begin
      n_tests = n_tests + 1;
      if (s !== e) begin
        errors = errors + 1;
        $display("[FAIL] %0t got %h want %h", $time, s, e);
      end
    end
  endtask
  task stop_test;
    begin
      $display("%0d checks %0d errors", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  // Writes judged on the write data, reads on the result
  task op(input [1:0] c, input b, input [15:0] o, e);
    begin
      {op_valid, op_code, op_byte, op_offset} <= {1'b1, c, b, o};
      @(posedge sys_clk) op_valid <= 0;
      repeat (2) @(posedge sys_clk);
      chk(c == 2'h3 ? mem_wdata_q[23:16] : c[1] ? mem_wdata_q[15:0] : rd_data_q, e);
    end
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1;
    @(posedge sys_clk) {page_wr, op_offset} <= {1'b1, 16'h0081};
    @(posedge sys_clk) page_wr <= 0;
    op(2'h0, 0, 16'h1234, 16'h8851);
    chk(mem_addr_q, 24'h811234);
    chk(table_page_select, 8'h81);
    chk(mem_cfg_q, 1'b1);
    op(2'h0, 1, 16'h1235, 16'h0088);
    op(2'h1, 0, 16'h1234, 16'h001a);
    op(2'h1, 1, 16'h1234, 16'h001a);
    op(2'h1, 1, 16'h1235, 16'h0000);
    op(2'h2, 1, 16'h12a5, 16'ha5a5);
    chk(mem_lane_q, 3'h2);
    op(2'h3, 0, 16'h1234, 16'h0034);
    chk(mem_lane_q, 3'h4);
    $display("table ops done");
    pc_step <= 1;
    repeat (2) @(posedge sys_clk);
    pc_step <= 0;
    @(posedge sys_clk) chk(pc_q, 24'h000004);
    $display("pc done");
    stop_test;
  end
  initial begin
    #5000;
    errors = errors + 1;
    stop_test;
  end
endmodule
